/* rtl/free_timer_pkg.sv */
// Constants and carrier types of the free-running timer block.
package free_timer_pkg;

	localparam logic [15:0] COUNT_RELOAD   = 16'hfffc;
	localparam logic [15:0] COUNT_TOP      = 16'hffff;
	localparam logic [15:0] COMPARE_RESET  = 16'h8000;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;

	localparam logic [5:0] OFS_CTRL_ONE    = 6'h00;
	localparam logic [5:0] OFS_CTRL_TWO    = 6'h04;
	localparam logic [5:0] OFS_STATUS      = 6'h08;
	localparam logic [5:0] OFS_COUNT_HI    = 6'h0c;
	localparam logic [5:0] OFS_COUNT_LO    = 6'h10;
	localparam logic [5:0] OFS_SHADOW_HI   = 6'h14;
	localparam logic [5:0] OFS_SHADOW_LO   = 6'h18;
	localparam logic [5:0] OFS_CAP_ONE_HI  = 6'h1c;
	localparam logic [5:0] OFS_CAP_ONE_LO  = 6'h20;
	localparam logic [5:0] OFS_CAP_TWO_HI  = 6'h24;
	localparam logic [5:0] OFS_CAP_TWO_LO  = 6'h28;
	localparam logic [5:0] OFS_CMP_ONE_HI  = 6'h2c;
	localparam logic [5:0] OFS_CMP_ONE_LO  = 6'h30;
	localparam logic [5:0] OFS_CMP_TWO_HI  = 6'h34;
	localparam logic [5:0] OFS_CMP_TWO_LO  = 6'h38;

	// First control register fields.
	localparam int C1_OVF_IE   = 7;
	localparam int C1_CAP_IE   = 6;
	localparam int C1_CMP_IE   = 5;
	localparam int C1_CAP1_EDG = 4;
	localparam int C1_PWM      = 3;
	localparam int C1_ONE_PULS = 2;
	localparam int C1_LVL_ONE  = 1;
	localparam int C1_LVL_TWO  = 0;
	// Second control register fields.
	localparam int C2_CLK_LSB  = 0;
	localparam int C2_EXT_EDG  = 2;
	localparam int C2_CAP2_EDG = 3;
	localparam int C2_OUT1_EN  = 4;
	localparam int C2_OUT2_EN  = 5;
	// Flag positions, also their bits in the status register.
	localparam int F_OVF  = 0;
	localparam int F_CAP1 = 1;
	localparam int F_CAP2 = 2;
	localparam int F_CMP1 = 3;
	localparam int F_CMP2 = 4;

	localparam logic [1:0] CS_DIV4 = 2'b00;
	localparam logic [1:0] CS_DIV8 = 2'b01;
	localparam logic [1:0] CS_DIV2 = 2'b10;
	localparam logic [1:0] CS_EXT  = 2'b11;
	localparam logic [2:0] MASK_DIV2 = 3'h1;
	localparam logic [2:0] MASK_DIV4 = 3'h3;
	localparam logic [2:0] MASK_DIV8 = 3'h7;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [5:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avmm_req_type;

endpackage

/* rtl/free_timer.sv */
// Free-running 16-bit timer with capture, compare and an Avalon-MM slave.
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module free_timer #(
	parameter bit         REDUCED   = 1'b0,
	parameter bit         SEP_VECS  = 1'b0,
	parameter logic [2:0] BONDED    = 3'h7
) (
	input  wire logic                          mclk,
	input  wire logic                          nrst,
	input  wire free_timer_pkg::avmm_req_type  avs_req,
	output logic                               avs_waitrequest,
	output logic [31:0]                        avs_readdata,
	input  wire logic                          capture_input_one,
	input  wire logic                          capture_input_two,
	input  wire logic                          external_count_clock,
	output logic                               compare_output_one,
	output logic                               compare_output_two,
	output logic                               timer_irq,
	output logic                               overflow_irq,
	output logic                               capture_irq,
	output logic                               compare_irq
);
	import free_timer_pkg::*;

	initial begin
		if (BONDED == 3'h0 && REDUCED) begin
			$error("free_timer: no input pin bonded");
		end
	end

	typedef struct packed {
		logic [15:0]      count;
		logic [2:0]       presc;
		logic [7:0]       ctrl_one;
		logic [7:0]       ctrl_two;
		logic [4:0]       flags;
		logic [4:0]       armed;
		logic [15:0]      cap_one;
		logic [15:0]      cap_two;
		logic [15:0]      cmp_one;
		logic [15:0]      cmp_two;
		logic [1:0]       cap_hold;
		logic [1:0][7:0]  lo_buf;
		logic [1:0]       buf_valid;
		logic [7:0]       snap;
		logic             out_one;
		logic             out_two;
		logic             ack;
		logic [31:0]      rdata;
		logic [2:0]       pin_prev;
	} timer_state_type;

	logic [1:0]       rst_sync;
	logic             rst_n;
	logic [2:0]       pin_meta;
	logic [2:0]       pin_sync;
	logic [2:0]       pin_now;
	timer_state_type  st;
	timer_state_type  next_st;
	logic             req;
	logic             acc;
	logic             tick;
	logic             ext_edge;
	logic [15:0]      count_inc;
	logic             cap_one_edge;
	logic             cap_two_edge;
	logic             hit_one;
	logic             hit_two;
	logic             pwm_restart;
	logic [2:0]       div_mask;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Pins are order {external clock, capture two, capture one}.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 3'h7;
			pin_sync <= 3'h7;
		end else begin
			pin_meta <= {external_count_clock, capture_input_two,
				capture_input_one};
			pin_sync <= pin_meta;
		end
	end
	assign pin_now = pin_sync | ~BONDED;

	assign req = avs_req.read | avs_req.write;
	assign acc = req & st.ack;
	assign avs_waitrequest = req & ~st.ack;
	assign avs_readdata = st.rdata;

	function automatic logic is_addr(input logic [5:0] ofs);
		is_addr = acc && avs_req.address == ofs;
	endfunction

	function automatic logic edge_seen(input logic now, input logic prev,
		input logic rising);
		edge_seen = rising ? (now & ~prev) : (~now & prev);
	endfunction

	always_comb begin
		unique case (st.ctrl_two[C2_CLK_LSB +: 2])
			CS_DIV2: div_mask = MASK_DIV2;
			CS_DIV4: div_mask = MASK_DIV4;
			CS_DIV8: div_mask = MASK_DIV8;
			CS_EXT:  div_mask = MASK_DIV8;
		endcase
	end

	// The external clock is sampled twice before its edge is taken.
	assign ext_edge = edge_seen(pin_now[2], st.pin_prev[2],
		st.ctrl_two[C2_EXT_EDG]);
	assign tick = (st.ctrl_two[C2_CLK_LSB +: 2] == CS_EXT) ? ext_edge
		: ((st.presc & div_mask) == div_mask);
	assign count_inc = st.count + 16'h0001;
	assign cap_one_edge = edge_seen(pin_now[0], st.pin_prev[0],
		st.ctrl_one[C1_CAP1_EDG]);
	assign cap_two_edge = !REDUCED && edge_seen(pin_now[1],
		st.pin_prev[1], st.ctrl_two[C2_CAP2_EDG]);
	assign hit_one = tick && count_inc == st.cmp_one;
	assign hit_two = tick && count_inc == st.cmp_two;
	assign pwm_restart = st.ctrl_one[C1_PWM] && hit_two;

	always_comb begin
		logic [4:0] set_f;
		logic [4:0] clr_f;
		logic       wr_lo;
		logic       reload;
		set_f = 5'h00;
		clr_f = 5'h00;
		wr_lo = 1'b0;
		reload = 1'b0;
		next_st = st;
		next_st.presc = st.presc + 3'h1;
		next_st.pin_prev = pin_now;
		next_st.ack = req & ~st.ack;

		// Read data is formed one cycle before the accepting edge.
		if (req && !st.ack) begin
			next_st.rdata = 32'h0000_0000;
			unique case (avs_req.address)
				OFS_CTRL_ONE:   next_st.rdata[7:0] = st.ctrl_one;
				OFS_CTRL_TWO:   next_st.rdata[7:0] = st.ctrl_two;
				OFS_STATUS:     next_st.rdata[4:0] = st.flags;
				OFS_COUNT_HI,
				OFS_SHADOW_HI:  next_st.rdata[7:0] = st.count[15:8];
				OFS_COUNT_LO:   next_st.rdata[7:0] = st.buf_valid[0]
					? st.lo_buf[0] : st.count[7:0];
				OFS_SHADOW_LO:  next_st.rdata[7:0] = st.buf_valid[1]
					? st.lo_buf[1] : st.count[7:0];
				OFS_CAP_ONE_HI: next_st.rdata[7:0] = st.cap_one[15:8];
				OFS_CAP_ONE_LO: next_st.rdata[7:0] = st.cap_one[7:0];
				OFS_CAP_TWO_HI: next_st.rdata[7:0] = st.cap_two[15:8];
				OFS_CAP_TWO_LO: next_st.rdata[7:0] = st.cap_two[7:0];
				OFS_CMP_ONE_HI: next_st.rdata[7:0] = st.cmp_one[15:8];
				OFS_CMP_ONE_LO: next_st.rdata[7:0] = st.cmp_one[7:0];
				OFS_CMP_TWO_HI: next_st.rdata[7:0] =
					REDUCED ? 8'h00 : st.cmp_two[15:8];
				OFS_CMP_TWO_LO: next_st.rdata[7:0] =
					REDUCED ? 8'h00 : st.cmp_two[7:0];
				default:        next_st.rdata = 32'h0000_0000;
			endcase
			next_st.snap = st.count[7:0];
		end

		wr_lo = acc && avs_req.write && avs_req.byteenable[0];
		if (wr_lo) begin
			unique case (avs_req.address)
				OFS_CTRL_ONE:   next_st.ctrl_one = avs_req.writedata[7:0];
				OFS_CTRL_TWO:   next_st.ctrl_two = avs_req.writedata[7:0];
				OFS_CMP_ONE_HI: next_st.cmp_one[15:8] =
					avs_req.writedata[7:0];
				OFS_CMP_ONE_LO: next_st.cmp_one[7:0] =
					avs_req.writedata[7:0];
				OFS_CMP_TWO_HI: next_st.cmp_two[15:8] =
					avs_req.writedata[7:0];
				OFS_CMP_TWO_LO: next_st.cmp_two[7:0] =
					avs_req.writedata[7:0];
				default:        next_st.cmp_two = next_st.cmp_two;
			endcase
		end
		reload = wr_lo && (avs_req.address == OFS_COUNT_LO ||
			avs_req.address == OFS_SHADOW_LO);

		// High byte read freezes the low byte until its low byte read.
		if (acc && avs_req.read) begin
			if (avs_req.address == OFS_COUNT_HI && !st.buf_valid[0]) begin
				next_st.lo_buf[0] = st.snap;
				next_st.buf_valid[0] = 1'b1;
			end
			if (avs_req.address == OFS_SHADOW_HI && !st.buf_valid[1]) begin
				next_st.lo_buf[1] = st.snap;
				next_st.buf_valid[1] = 1'b1;
			end
			if (avs_req.address == OFS_COUNT_LO) begin
				next_st.buf_valid[0] = 1'b0;
			end
			if (avs_req.address == OFS_SHADOW_LO) begin
				next_st.buf_valid[1] = 1'b0;
			end
			if (avs_req.address == OFS_CAP_ONE_HI) begin
				next_st.cap_hold[0] = 1'b1;
			end
			if (avs_req.address == OFS_CAP_TWO_HI) begin
				next_st.cap_hold[1] = 1'b1;
			end
			if (avs_req.address == OFS_CAP_ONE_LO) begin
				next_st.cap_hold[0] = 1'b0;
			end
			if (avs_req.address == OFS_CAP_TWO_LO) begin
				next_st.cap_hold[1] = 1'b0;
			end
		end

		// Counter: software reload first, then mode restarts, then ticks.
		if (reload) begin
			next_st.count = COUNT_RELOAD;
		end else if (pwm_restart ||
			(st.ctrl_one[C1_ONE_PULS] && cap_one_edge)) begin
			next_st.count = COUNT_RELOAD;
		end else if (tick) begin
			next_st.count = count_inc;
			if (st.count == COUNT_TOP) begin
				set_f[F_OVF] = 1'b1;
			end
		end

		// Capture is blocked between the high and low byte reads.
		if (cap_one_edge && !st.cap_hold[0] &&
			!st.ctrl_one[C1_PWM] && !st.ctrl_one[C1_ONE_PULS]) begin
			next_st.cap_one = st.count;
			set_f[F_CAP1] = 1'b1;
		end
		if (cap_two_edge && !st.cap_hold[1]) begin
			next_st.cap_two = st.count;
			set_f[F_CAP2] = 1'b1;
		end

		if (hit_one) begin
			set_f[F_CMP1] = 1'b1;
			if (st.ctrl_two[C2_OUT1_EN]) begin
				next_st.out_one = st.ctrl_one[C1_LVL_ONE];
			end
		end
		if (hit_two) begin
			set_f[F_CMP2] = !REDUCED;
			if (st.ctrl_one[C1_PWM] && st.ctrl_two[C2_OUT1_EN]) begin
				next_st.out_one = st.ctrl_one[C1_LVL_TWO];
			end else if (st.ctrl_two[C2_OUT2_EN]) begin
				next_st.out_two = st.ctrl_one[C1_LVL_TWO];
			end
		end
		if (st.ctrl_one[C1_ONE_PULS] && cap_one_edge &&
			st.ctrl_two[C2_OUT1_EN]) begin
			next_st.out_one = st.ctrl_one[C1_LVL_TWO];
		end

		// Flag clear: status read arms, matching low byte access clears.
		if (is_addr(OFS_STATUS) && avs_req.read) begin
			next_st.armed = st.armed | st.flags;
		end
		clr_f[F_OVF]  = is_addr(OFS_COUNT_LO) && st.armed[F_OVF];
		clr_f[F_CAP1] = is_addr(OFS_CAP_ONE_LO) && st.armed[F_CAP1];
		clr_f[F_CAP2] = is_addr(OFS_CAP_TWO_LO) && st.armed[F_CAP2];
		clr_f[F_CMP1] = is_addr(OFS_CMP_ONE_LO) && st.armed[F_CMP1];
		clr_f[F_CMP2] = is_addr(OFS_CMP_TWO_LO) && st.armed[F_CMP2];
		next_st.armed = next_st.armed & ~clr_f;
		// A flag raised in the clearing cycle survives.
		next_st.flags = (st.flags & ~clr_f) | set_f;
		if (REDUCED) begin
			next_st.flags[F_CAP2] = 1'b0;
			next_st.flags[F_CMP2] = 1'b0;
		end
	end

	// Every timer starts from the same state so instances run in step.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.count <= COUNT_RELOAD;
			st.ctrl_one <= CTRL_RESET;
			st.ctrl_two <= CTRL_RESET;
			st.cmp_one <= COMPARE_RESET;
			st.cmp_two <= COMPARE_RESET;
			st.out_one <= 1'b1;
			st.out_two <= 1'b1;
			st.pin_prev <= 3'h7;
		end else begin
			st <= next_st;
		end
	end

	assign compare_output_one = st.out_one;
	assign compare_output_two = st.out_two;
	assign overflow_irq = st.flags[F_OVF] & st.ctrl_one[C1_OVF_IE];
	assign capture_irq = (st.flags[F_CAP1] | st.flags[F_CAP2])
		& st.ctrl_one[C1_CAP_IE];
	assign compare_irq = (st.flags[F_CMP1] | st.flags[F_CMP2])
		& st.ctrl_one[C1_CMP_IE];
	assign timer_irq = SEP_VECS ? 1'b0
		: (overflow_irq | capture_irq | compare_irq);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_reload_on_write: assert property (
		acc && avs_req.write && avs_req.byteenable[0] &&
		avs_req.address == OFS_SHADOW_LO |=> st.count == COUNT_RELOAD)
		else $error("counter not reloaded by low byte write");
	chk_overflow_sets: assert property (
		tick && st.count == COUNT_TOP && !acc && !pwm_restart &&
		!st.ctrl_one[C1_ONE_PULS]
		|=> st.flags[F_OVF] && st.count == 16'h0000)
		else $error("overflow did not set flag or wrap");
	chk_count_step: assert property (
		tick && !acc && !pwm_restart && !st.ctrl_one[C1_ONE_PULS]
		|=> st.count == $past(st.count) + 16'h0001)
		else $error("counter did not advance by one");
	chk_div_eight: assert property (
		tick && st.ctrl_two[C2_CLK_LSB +: 2] == CS_DIV8
		|-> st.presc == MASK_DIV8)
		else $error("divide by eight tick misplaced");
	chk_shadow_keeps: assert property (
		st.flags[F_OVF] && acc && avs_req.address == OFS_SHADOW_LO
		|=> st.flags[F_OVF])
		else $error("shadow low access cleared overflow");
	chk_unarmed_keeps: assert property (
		st.flags[F_OVF] && !st.armed[F_OVF] && !acc ##1
		acc && avs_req.address == OFS_COUNT_LO && !st.armed[F_OVF]
		|=> st.flags[F_OVF])
		else $error("overflow cleared without status read");
	chk_low_buffer: assert property (
		st.buf_valid[0] && !(acc && avs_req.address == OFS_COUNT_LO)
		|=> st.buf_valid[0] && st.lo_buf[0] == $past(st.lo_buf[0]))
		else $error("buffered low byte changed");
	chk_reduced_flags: assert property (
		REDUCED |-> st.flags[F_CAP2] == 1'b0 && st.flags[F_CMP2] == 1'b0)
		else $error("reduced variant flag set");
	chk_wait_then_ack: assert property (
		req && !st.ack |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
		else $error("slave did not answer in one wait cycle");

	cov_overflow: cover property (tick && st.count == COUNT_TOP);
	cov_ext_tick: cover property (
		ext_edge && st.ctrl_two[C2_CLK_LSB +: 2] == CS_EXT);
	cov_capture: cover property (cap_one_edge && !st.cap_hold[0]);
	cov_flag_clear: cover property (
		st.flags[F_OVF] ##1 !st.flags[F_OVF]);

endmodule

/* verification/free_timer_far.sv */
// Pin-side model that drives the capture pins and the external count clock.
`timescale 1ns/10ps
module free_timer_far (
	input  wire logic mclk,
	output logic      external_count_clock,
	output logic      capture_input_one,
	output logic      capture_input_two
);
	initial begin
		external_count_clock = 1'b0;
		// Capture pins rest high; only capture one is ever pulled low.
		capture_input_one = 1'b1;
		capture_input_two = 1'b1;
	end

	// Each pulse spans ten CPU clocks, well under a quarter of its rate.
	task automatic edges(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk) external_count_clock <= 1'b1;
			repeat (5) @(posedge mclk);
			external_count_clock <= 1'b0;
			repeat (4) @(posedge mclk);
		end
		repeat (6) @(posedge mclk);
	endtask

	task automatic capture(input logic v);
		@(posedge mclk) capture_input_one <= v;
		repeat (6) @(posedge mclk);
	endtask

	task automatic hold(input logic v);
		@(posedge mclk) external_count_clock <= v;
		repeat (6) @(posedge mclk);
	endtask
endmodule

/* verification/free_timer_test.sv */
// Self-checking bench for the free-running timer register view.
`timescale 1ns/10ps
module free_timer_test;
	import free_timer_pkg::*;
	logic         mclk;
	logic         nrst;
	avmm_req_type req;
	logic         avs_waitrequest;
	logic [31:0]  avs_readdata;
	logic         ext_clk;
	logic         cap_one;
	logic         cap_two;
	logic         timer_irq;
	logic         overflow_irq;
	logic         capture_irq;
	logic         compare_irq;
	logic         out_one;
	logic         out_two;
	int           n_fail;
	int           n_checks;
	int           cycles;
	logic [7:0]   q;
	logic [7:0]   a;

	free_timer i_dut (
		.mclk                 (mclk),
		.nrst                 (nrst),
		.avs_req              (req),
		.avs_waitrequest      (avs_waitrequest),
		.avs_readdata         (avs_readdata),
		.capture_input_one    (cap_one),
		.capture_input_two    (cap_two),
		.external_count_clock (ext_clk),
		.compare_output_one   (out_one),
		.compare_output_two   (out_two),
		.timer_irq            (timer_irq),
		.overflow_irq         (overflow_irq),
		.capture_irq          (capture_irq),
		.compare_irq          (compare_irq)
	);

	free_timer_far i_far (
		.mclk                 (mclk),
		.external_count_clock (ext_clk),
		.capture_input_one    (cap_one),
		.capture_input_two    (cap_two)
	);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic wrap_up();
		if (n_fail == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic check(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One Avalon transfer; held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [5:0] adr,
			input logic [7:0] d, output logic [7:0] rd);
		@(posedge mclk);
		req.read       <= ~wr;
		req.write      <= wr;
		req.address    <= adr;
		req.byteenable <= 4'h1;
		req.writedata  <= {24'h000000, d};
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[7:0];
		req.read  <= 1'b0;
		req.write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] adr, input logic [7:0] d);
		logic [7:0] dummy;
		bus(1'b1, adr, d, dummy);
	endtask

	task automatic rd(input logic [5:0] adr, input string name,
			input logic [7:0] exp);
		logic [7:0] v;
		bus(1'b0, adr, 8'h00, v);
		check(name, {24'h000000, v}, {24'h000000, exp});
	endtask

	task automatic t_reset_values();
		check("out_one_reset", {31'h0, out_one}, 32'h1);
		rd(OFS_CTRL_ONE, "ctrl_one", CTRL_RESET);
		rd(OFS_CMP_ONE_HI, "compare_one_hi", COMPARE_RESET[15:8]);
		rd(6'h3c, "unmapped", 8'h00);
	endtask

	task automatic t_reload();
		wr(OFS_CTRL_TWO, 8'h07);
		wr(OFS_COUNT_LO, 8'h5a);
		rd(OFS_COUNT_HI, "count_hi", COUNT_RELOAD[15:8]);
		rd(OFS_COUNT_LO, "count_lo", COUNT_RELOAD[7:0]);
		i_far.edges(1);
		rd(OFS_COUNT_LO, "count_lo_tick", 8'hfd);
		wr(OFS_SHADOW_LO, 8'h00);
		rd(OFS_SHADOW_HI, "shadow_hi", COUNT_RELOAD[15:8]);
		rd(OFS_SHADOW_LO, "shadow_lo", COUNT_RELOAD[7:0]);
	endtask

	task automatic t_overflow();
		rd(OFS_STATUS, "status_before", 8'h00);
		i_far.edges(5);
		rd(OFS_COUNT_HI, "wrap_hi", 8'h00);
		rd(OFS_COUNT_LO, "wrap_lo", 8'h01);
		rd(OFS_SHADOW_HI, "wrap_shadow_hi", 8'h00);
		rd(OFS_SHADOW_LO, "wrap_shadow_lo", 8'h01);
		check("irq_masked", {31'h0, overflow_irq}, 32'h0);
		wr(OFS_CTRL_ONE, 8'h80);
		@(posedge mclk);
		check("overflow_irq", {31'h0, overflow_irq}, 32'h1);
		check("timer_irq", {31'h0, timer_irq}, 32'h1);
		rd(OFS_STATUS, "status_set", 8'h01);
		rd(OFS_SHADOW_LO, "shadow_lo_again", 8'h01);
		rd(OFS_STATUS, "status_kept", 8'h01);
		rd(OFS_COUNT_LO, "count_lo_clear", 8'h01);
		rd(OFS_STATUS, "status_clear", 8'h00);
		check("irq_cleared", {31'h0, overflow_irq}, 32'h0);
		wr(OFS_CTRL_ONE, 8'h00);
	endtask

	task automatic t_buffer();
		wr(OFS_COUNT_LO, 8'h00);
		rd(OFS_COUNT_HI, "buf_hi", 8'hff);
		i_far.edges(2);
		rd(OFS_COUNT_HI, "buf_hi_again", 8'hff);
		rd(OFS_COUNT_LO, "buf_lo", 8'hfc);
		rd(OFS_COUNT_LO, "live_lo", 8'hfe);
	endtask

	task automatic t_edge();
		wr(OFS_CTRL_TWO, 8'h03);
		wr(OFS_COUNT_LO, 8'h00);
		i_far.hold(1'b1);
		rd(OFS_COUNT_LO, "edge_rise", 8'hfc);
		i_far.hold(1'b0);
		rd(OFS_COUNT_LO, "edge_fall", 8'hfd);
	endtask

	// Falling capture edge on a stopped counter, then the two-step clear.
	task automatic t_capture();
		wr(OFS_CTRL_ONE, 8'h40);
		wr(OFS_COUNT_LO, 8'h00);
		i_far.capture(1'b0);
		check("capture_irq", {31'h0, capture_irq}, 32'h1);
		check("capture_timer_irq", {31'h0, timer_irq}, 32'h1);
		rd(OFS_STATUS, "status_capture", 8'h02);
		rd(OFS_CAP_ONE_HI, "capture_hi", 8'hff);
		rd(OFS_CAP_ONE_LO, "capture_lo", 8'hfc);
		@(posedge mclk);
		check("capture_irq_clear", {31'h0, capture_irq}, 32'h0);
		i_far.capture(1'b1);
		rd(OFS_STATUS, "status_no_rise", 8'h00);
	endtask

	// Compare one at FFFEh drives output one to level zero.
	task automatic t_compare();
		wr(OFS_CMP_ONE_HI, 8'hff);
		wr(OFS_CMP_ONE_LO, 8'hfe);
		wr(OFS_CTRL_TWO, 8'h13);
		wr(OFS_CTRL_ONE, 8'h20);
		wr(OFS_COUNT_LO, 8'h00);
		i_far.edges(2);
		check("out_one_hit", {31'h0, out_one}, 32'h0);
		check("out_two_idle", {31'h0, out_two}, 32'h1);
		check("compare_irq", {31'h0, compare_irq}, 32'h1);
		rd(OFS_STATUS, "status_compare", 8'h08);
		rd(OFS_CMP_ONE_LO, "compare_lo", 8'hfe);
		@(posedge mclk);
		check("compare_irq_clear", {31'h0, compare_irq}, 32'h0);
		wr(OFS_CTRL_ONE, 8'h00);
	endtask

	// Two live low reads 32 clocks apart differ by 32 over the divider.
	task automatic t_divide();
		logic [1:0] sel [3];
		logic [7:0] step [3];
		sel = '{CS_DIV2, CS_DIV4, CS_DIV8};
		step = '{8'h10, 8'h08, 8'h04};
		for (int i = 0; i < 3; i++) begin
			wr(OFS_CTRL_TWO, {6'h00, sel[i]});
			bus(1'b0, OFS_COUNT_LO, 8'h00, a);
			repeat (29) @(posedge mclk);
			bus(1'b0, OFS_COUNT_LO, 8'h00, q);
			check("divide_step", {24'h0, q - a}, {24'h0, step[i]});
		end
	endtask

	initial begin
		n_fail = 0;
		n_checks = 0;
		cycles = 0;
		nrst = 1'b0;
		req = '0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		t_reset_values();
		t_reload();
		t_overflow();
		t_buffer();
		t_edge();
		t_capture();
		t_compare();
		t_divide();
		wrap_up();
	end
endmodule
